// ### plp_ctl.sv
// plp_ctl: sixteen level program priority controller with context switch
// assumes the cpu sequencer issues one special register operation at a
// time, marks instruction boundaries, and stalls while cpu_hold_o is high
`timescale 1ns/100ps
module plp_ctl (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic op_valid_i,
  input wire logic [3:0] op_code_i,
  input wire logic op_sel_i,
  input wire logic [plp_pkg::DATA_W-1:0] accum_i,
  input wire logic [plp_pkg::DEV_SEL_W-1:0] device_register_select_i,
  input wire logic instr_boundary_i,
  input wire logic [plp_pkg::EXT_W-1:0] ext_irq_i,
  input wire logic [plp_pkg::CAUSE_W-1:0] status_cause_i,
  input wire logic [plp_pkg::CTX_W-1:0] ctx_work_i,
  output logic [plp_pkg::DATA_W-1:0] read_data_o,
  output logic read_valid_o,
  output logic [plp_pkg::LVL_W-1:0] current_level_o,
  output logic [plp_pkg::LVL_W-1:0] previous_level_o,
  output logic [plp_pkg::LVL_W-1:0] highest_pending_level_o,
  output logic [plp_pkg::DATA_W-1:0] level_enable_mask_o,
  output logic [plp_pkg::DATA_W-1:0] level_request_flags_o,
  output logic interrupts_on_o,
  output logic cpu_hold_o,
  output logic switch_done_o,
  output logic [plp_pkg::CTX_W-1:0] ctx_restore_o,
  output logic device_io_transfer_o,
  output logic [plp_pkg::DEV_SEL_W-1:0] device_register_select_o,
  output logic [plp_pkg::DATA_W-1:0] device_data_o
);

  // highest set bit wins, zero when nothing is pending
  function automatic logic [3:0] plp_prio_enc(input logic [15:0] vec);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < plp_pkg::LEVELS; i++) begin
      if (vec[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : plp_prio_enc

  // effect of a software operation on one 16-bit register
  function automatic logic [15:0] plp_apply(
    input logic [15:0] cur,
    input logic [3:0] op,
    input logic [15:0] acc
  );
    logic [15:0] res;
    res = cur;
    if (op == plp_pkg::PLP_OP_WRITE) begin
      res = acc;
    end else if (op == plp_pkg::PLP_OP_MSET) begin
      res = cur | acc;
    end else if (op == plp_pkg::PLP_OP_MCLR) begin
      res = cur & ~acc;
    end
    return res;
  endfunction : plp_apply

  logic [15:0] mask_reg;
  logic [15:0] mask_next;
  logic [15:0] req_reg;
  logic [15:0] req_next;
  logic [3:0] cur_level_reg;
  logic [3:0] prev_level_reg;
  logic [3:0] target_reg;
  logic [3:0] pending_reg;
  logic intr_on_reg;
  logic intr_on_next;
  logic [15:0] read_data_reg;
  logic read_valid_reg;
  logic hold_reg;
  logic done_reg;
  logic dev_strobe_reg;
  logic [10:0] dev_sel_reg;
  logic [15:0] dev_data_reg;
  plp_pkg::plp_state_e state_reg;
  plp_pkg::plp_state_e state_next;
  logic [plp_pkg::SW_CNT_W-1:0] cnt_reg;
  logic [plp_pkg::SW_CNT_W-1:0] cnt_next;
  logic [4:0] ext_s1_reg;
  logic [4:0] ext_s2_reg;
  logic [4:0] ext_s3_reg;
  logic [4:0] ext_lvl_reg;
  logic [4:0] ext_lvl_next;
  logic [4:0] ext_rise;
  logic [15:0] hw_set;
  logic [15:0] sw_req;
  logic [15:0] giveup_clr;
  logic [15:0] armed;
  logic op_mask;
  logic op_req;
  logic is_read;
  logic is_giveup;
  logic is_devio;
  logic switch_req;
  logic cnt_last;

  localparam logic [plp_pkg::SW_CNT_W-1:0] CNT_LAST =
    plp_pkg::SW_CNT_W'(plp_pkg::SWITCH_CYCLES - 1);

  // operation decode
  assign op_mask = op_valid_i && (op_sel_i == plp_pkg::SEL_MASK);
  assign op_req = op_valid_i && (op_sel_i == plp_pkg::SEL_REQ);
  assign is_read = op_valid_i && (op_code_i == plp_pkg::PLP_OP_READ);
  assign is_giveup = op_valid_i && (op_code_i == plp_pkg::PLP_OP_GIVE_UP);
  assign is_devio = op_valid_i && (op_code_i == plp_pkg::PLP_OP_DEV_IO);

  // external lines: a change counts once stages two and three agree
  assign ext_lvl_next = (ext_s2_reg & ext_s3_reg) |
                        (ext_lvl_reg & (ext_s2_reg | ext_s3_reg));
  assign ext_rise = ext_lvl_next & ~ext_lvl_reg;

  // hardware request sources; levels 10-13 lines are shared by the
  // sources of that level, telling them apart is outside this block
  always_comb begin
    hw_set = 16'h0000;
    hw_set[plp_pkg::EXT_LEVEL_0] = ext_rise[0];
    hw_set[plp_pkg::EXT_LEVEL_1] = ext_rise[1];
    hw_set[plp_pkg::EXT_LEVEL_2] = ext_rise[2];
    hw_set[plp_pkg::EXT_LEVEL_3] = ext_rise[3];
    hw_set[plp_pkg::EXT_LEVEL_4] = ext_rise[4];
    hw_set[plp_pkg::STATUS_LEVEL] = |status_cause_i;
  end

  // mask changes by software only
  assign mask_next = op_mask ? plp_apply(mask_reg, op_code_i, accum_i)
                             : mask_reg;
  assign sw_req = op_req ? plp_apply(req_reg, op_code_i, accum_i)
                         : req_reg;
  assign giveup_clr = is_giveup ? (16'h0001 << cur_level_reg)
                                : 16'h0000;
  // a hardware set in the same cycle as a software clear wins
  assign req_next = (sw_req & ~giveup_clr) | hw_set;

  assign intr_on_next =
    (op_valid_i && op_code_i == plp_pkg::PLP_OP_INTR_ON) ? 1'b1
    : (op_valid_i && op_code_i == plp_pkg::PLP_OP_INTR_OFF) ? 1'b0
    : intr_on_reg;

  assign armed = mask_reg & req_reg;
  // level changes only at an instruction boundary and with switching on
  assign switch_req = intr_on_reg && instr_boundary_i &&
                      (pending_reg != cur_level_reg);
  assign cnt_last = (cnt_reg == CNT_LAST);

  // switch sequencer: save, load, then fill out the switch time
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      plp_pkg::PLP_ST_IDLE: begin
        cnt_next = '0;
        if (switch_req) begin
          state_next = plp_pkg::PLP_ST_SAVE;
        end
      end
      plp_pkg::PLP_ST_SAVE: begin
        cnt_next = cnt_reg + 1'b1;
        state_next = plp_pkg::PLP_ST_LOAD;
      end
      plp_pkg::PLP_ST_LOAD: begin
        cnt_next = cnt_reg + 1'b1;
        state_next = plp_pkg::PLP_ST_WAIT;
      end
      plp_pkg::PLP_ST_WAIT: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_last) begin
          state_next = plp_pkg::PLP_ST_IDLE;
          cnt_next = '0;
        end
      end
      default: begin
        state_next = plp_pkg::PLP_ST_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  // stage one is read by stage two only
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_s1_reg <= '0;
      ext_s2_reg <= '0;
      ext_s3_reg <= '0;
      ext_lvl_reg <= '0;
    end else begin
      ext_s1_reg <= ext_irq_i;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      ext_lvl_reg <= ext_lvl_next;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_reg <= plp_pkg::MASK_RST;
      req_reg <= plp_pkg::REQ_RST;
      intr_on_reg <= plp_pkg::INTR_ON_RST;
      pending_reg <= plp_pkg::LEVEL_RST;
    end else begin
      mask_reg <= mask_next;
      req_reg <= req_next;
      intr_on_reg <= intr_on_next;
      pending_reg <= plp_prio_enc(armed);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= plp_pkg::PLP_ST_IDLE;
      cnt_reg <= '0;
      cur_level_reg <= plp_pkg::LEVEL_RST;
      prev_level_reg <= plp_pkg::LEVEL_RST;
      target_reg <= plp_pkg::LEVEL_RST;
      hold_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= (state_reg == plp_pkg::PLP_ST_WAIT) && cnt_last;
      if (state_reg == plp_pkg::PLP_ST_IDLE && switch_req) begin
        hold_reg <= 1'b1;
        target_reg <= pending_reg;
      end else if (state_reg == plp_pkg::PLP_ST_WAIT && cnt_last) begin
        hold_reg <= 1'b0;
      end
      if (state_reg == plp_pkg::PLP_ST_SAVE) begin
        prev_level_reg <= cur_level_reg;
      end
      if (state_reg == plp_pkg::PLP_ST_LOAD) begin
        cur_level_reg <= target_reg;
      end
    end
  end

  // accumulator read and device transfer answers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      read_data_reg <= 16'h0000;
      read_valid_reg <= 1'b0;
      dev_strobe_reg <= 1'b0;
      dev_sel_reg <= 11'h000;
      dev_data_reg <= 16'h0000;
    end else begin
      read_valid_reg <= is_read;
      if (is_read) begin
        read_data_reg <= (op_sel_i == plp_pkg::SEL_REQ) ? req_reg
                                                        : mask_reg;
      end
      dev_strobe_reg <= is_devio;
      if (is_devio) begin
        dev_sel_reg <= device_register_select_i;
        dev_data_reg <= accum_i;
      end
    end
  end

  // working set saved under the old level, new level read back
  plp_ctx_store u_ctx_store (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(state_reg == plp_pkg::PLP_ST_SAVE),
    .wr_level_i(cur_level_reg),
    .wr_data_i(ctx_work_i),
    .rd_en_i(state_reg == plp_pkg::PLP_ST_LOAD),
    .rd_level_i(target_reg),
    .rd_data_o(ctx_restore_o)
  );

  assign read_data_o = read_data_reg;
  assign read_valid_o = read_valid_reg;
  assign current_level_o = cur_level_reg;
  assign previous_level_o = prev_level_reg;
  assign highest_pending_level_o = pending_reg;
  assign level_enable_mask_o = mask_reg;
  assign level_request_flags_o = req_reg;
  assign interrupts_on_o = intr_on_reg;
  assign cpu_hold_o = hold_reg;
  assign switch_done_o = done_reg;
  assign device_io_transfer_o = dev_strobe_reg;
  assign device_register_select_o = dev_sel_reg;
  assign device_data_o = dev_data_reg;

endmodule : plp_ctl

// ### plp_pkg.sv
// plp_pkg: constants, opcodes and states of the program level controller
// assumes a single 250 MHz cpu clock shared by every user of the package
package plp_pkg;

  localparam int LEVELS = 16;
  localparam int LVL_W = 4;
  localparam int DATA_W = 16;
  localparam int DEV_SEL_W = 11;
  localparam int EXT_W = 5;
  localparam int CAUSE_W = 10;

  // request bit fed by each synchronised external line, index = line
  localparam logic [3:0] EXT_LEVEL_0 = 4'hA;
  localparam logic [3:0] EXT_LEVEL_1 = 4'hB;
  localparam logic [3:0] EXT_LEVEL_2 = 4'hC;
  localparam logic [3:0] EXT_LEVEL_3 = 4'hD;
  localparam logic [3:0] EXT_LEVEL_4 = 4'hF;
  localparam logic [3:0] STATUS_LEVEL = 4'hE;

  // context block: six working registers, program counter, indicators
  localparam int CTX_REGS = 7;
  localparam int CTX_FLAGS = 8;
  localparam int CTX_W = CTX_REGS * DATA_W + CTX_FLAGS;
  localparam int CTX_A_LSB = 0;
  localparam int CTX_D_LSB = 16;
  localparam int CTX_T_LSB = 32;
  localparam int CTX_L_LSB = 48;
  localparam int CTX_X_LSB = 64;
  localparam int CTX_B_LSB = 80;
  localparam int CTX_P_LSB = 96;
  // indicators O Q Z C M K PTM TG from bit 112 upward in that order
  localparam int CTX_FLAG_LSB = 112;

  // reset values
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] REQ_RST = 16'h0000;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic INTR_ON_RST = 1'b0;

  // level switch time, 1.0 us, and its length in clock cycles
  localparam int SWITCH_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SWITCH_CYCLES = SWITCH_TIME_NS / CLK_PERIOD_NS;
  localparam int SW_CNT_W = 8;

  // register select of special register operations
  localparam logic SEL_MASK = 1'b0;
  localparam logic SEL_REQ = 1'b1;

  typedef enum logic [3:0] {
    PLP_OP_NONE = 4'h0,
    PLP_OP_READ = 4'h1,
    PLP_OP_WRITE = 4'h2,
    PLP_OP_MSET = 4'h3,
    PLP_OP_MCLR = 4'h4,
    PLP_OP_GIVE_UP = 4'h5,
    PLP_OP_INTR_ON = 4'h6,
    PLP_OP_INTR_OFF = 4'h7,
    PLP_OP_DEV_IO = 4'h8
  } plp_op_e;

  // gray along idle -> save -> load -> wait -> idle
  typedef enum logic [1:0] {
    PLP_ST_IDLE = 2'b00,
    PLP_ST_SAVE = 2'b01,
    PLP_ST_LOAD = 2'b11,
    PLP_ST_WAIT = 2'b10
  } plp_state_e;

endpackage : plp_pkg

// ### plp_ctx_store.sv
// plp_ctx_store: sixteen context blocks held in flip-flops
// assumes one write and one read per cycle at most, both from the sequencer
`timescale 1ns/100ps
module plp_ctx_store (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic [plp_pkg::LVL_W-1:0] wr_level_i,
  input wire logic [plp_pkg::CTX_W-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [plp_pkg::LVL_W-1:0] rd_level_i,
  output logic [plp_pkg::CTX_W-1:0] rd_data_o
);

  logic [plp_pkg::CTX_W-1:0] block_reg [plp_pkg::LEVELS];
  logic [plp_pkg::CTX_W-1:0] rd_data_reg;

  // one block per level, indexed by the level number
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < plp_pkg::LEVELS; i++) begin
        block_reg[i] <= '0;
      end
    end else if (wr_en_i) begin
      block_reg[wr_level_i] <= wr_data_i;
    end
  end

  // registered read keeps the restore path off the decode timing
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_reg <= '0;
    end else if (rd_en_i) begin
      rd_data_reg <= block_reg[rd_level_i];
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule : plp_ctx_store

// ### plp_ctl_monitor.sv
// plp_ctl_monitor: port-level assertions for the level controller
// assumes it is bound to plp_ctl and sees only that module's ports
`timescale 1ns/100ps
module plp_ctl_monitor (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic op_valid_i,
  input wire logic [3:0] op_code_i,
  input wire logic op_sel_i,
  input wire logic [15:0] accum_i,
  input wire logic [10:0] device_register_select_i,
  input wire logic instr_boundary_i,
  input wire logic [15:0] read_data_o,
  input wire logic read_valid_o,
  input wire logic [3:0] current_level_o,
  input wire logic [3:0] previous_level_o,
  input wire logic [3:0] highest_pending_level_o,
  input wire logic [15:0] level_enable_mask_o,
  input wire logic [15:0] level_request_flags_o,
  input wire logic interrupts_on_o,
  input wire logic cpu_hold_o,
  input wire logic switch_done_o,
  input wire logic device_io_transfer_o,
  input wire logic [10:0] device_register_select_o,
  input wire logic [15:0] device_data_o
);
  logic [8:0] hold_cnt_reg;
  // mask ops only: request bits may also move by hardware
  wire mask_op = op_valid_i && !op_sel_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  function automatic logic [3:0] enc(input logic [15:0] v);
    enc = 4'h0;
    for (int i = 0; i < 16; i++)
      if (v[i]) enc = 4'(i);
  endfunction : enc
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) hold_cnt_reg <= 9'h000;
    else if (cpu_hold_o) hold_cnt_reg <= hold_cnt_reg + 9'h001;
    else hold_cnt_reg <= 9'h000;
  end
  chk_hold_length: assert property ($fell(cpu_hold_o) |->
    switch_done_o && hold_cnt_reg == 9'(plp_pkg::SWITCH_CYCLES))
    else $error("hold length");
  chk_switch_start: assert property (interrupts_on_o && !cpu_hold_o
    && instr_boundary_i && highest_pending_level_o != current_level_o
    |=> cpu_hold_o) else $error("switch not started");
  chk_prev_save: assert property ($rose(cpu_hold_o) |=>
    previous_level_o == $past(current_level_o) ##1
    current_level_o == $past(highest_pending_level_o, 3))
    else $error("level swap wrong");
  chk_pending_enc: assert property (highest_pending_level_o ==
    enc($past(level_enable_mask_o & level_request_flags_o)))
    else $error("pending level wrong");
  chk_read_value: assert property (op_valid_i &&
    op_code_i == plp_pkg::PLP_OP_READ |=> read_valid_o && read_data_o ==
    $past(op_sel_i ? level_request_flags_o : level_enable_mask_o))
    else $error("read value wrong");
  chk_mask_write: assert property (mask_op &&
    op_code_i == plp_pkg::PLP_OP_WRITE |=>
    level_enable_mask_o == $past(accum_i)) else $error("copy write");
  chk_mask_set: assert property (mask_op &&
    op_code_i == plp_pkg::PLP_OP_MSET |=> level_enable_mask_o ==
    $past(level_enable_mask_o | accum_i)) else $error("masked set");
  chk_mask_clear: assert property (mask_op &&
    op_code_i == plp_pkg::PLP_OP_MCLR |=> level_enable_mask_o ==
    $past(level_enable_mask_o & ~accum_i)) else $error("masked clear");
  chk_off_freeze: assert property (!interrupts_on_o && !cpu_hold_o
    |=> $stable(current_level_o)) else $error("level moved while off");
  chk_dev_io: assert property (op_valid_i &&
    op_code_i == plp_pkg::PLP_OP_DEV_IO |=> device_io_transfer_o &&
    device_register_select_o == $past(device_register_select_i) &&
    device_data_o == $past(accum_i)) else $error("device transfer");
  cov_switch: cover property (switch_done_o);
  cov_read: cover property (read_valid_o);
  cov_intr_on: cover property ($rose(interrupts_on_o));
endmodule : plp_ctl_monitor
bind plp_ctl plp_ctl_monitor mon (.clock_i, .rst_b_i, .op_valid_i,
  .op_code_i, .op_sel_i, .accum_i, .device_register_select_i,
  .instr_boundary_i, .read_data_o, .read_valid_o, .current_level_o,
  .previous_level_o, .highest_pending_level_o, .level_enable_mask_o,
  .level_request_flags_o, .interrupts_on_o, .cpu_hold_o, .switch_done_o,
  .device_io_transfer_o, .device_register_select_o, .device_data_o);

// ### plp_cpu_model.sv
// plp_cpu_model: cpu sequencer boundary and device request lines
// assumes dev_ready_i pulses for one cycle when a device gets ready
`timescale 1ns/100ps
module plp_cpu_model (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic cpu_hold_i,
  input wire logic [4:0] dev_ready_i,
  output logic instr_boundary_o,
  output logic [4:0] ext_irq_o,
  output logic [2:0] irq_cnt_o
);
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      instr_boundary_o <= 1'b0;
      ext_irq_o <= 5'h00;
      irq_cnt_o <= 3'h0;
    end else begin
      // two-cycle instructions, stalled while the switch runs
      instr_boundary_o <= !cpu_hold_i && !instr_boundary_o;
      if (dev_ready_i != 5'h00) begin
        ext_irq_o <= dev_ready_i;
        irq_cnt_o <= 3'h7;
      end else if (irq_cnt_o != 3'h0) begin
        irq_cnt_o <= irq_cnt_o - 3'h1;
      end else begin
        ext_irq_o <= 5'h00;
      end
    end
  end
endmodule : plp_cpu_model

// ### tb_top.sv
// tb_top: random and directed bench for the level controller
// assumes plp_ctl, plp_cpu_model and the bound monitor are compiled
`timescale 1ns/100ps
module tb_top;
  logic clock_i, rst_b_i, op_valid_i, op_sel_i, bnd, hold, rv, intr_on;
  logic done, dio;
  logic [3:0] op_code_i, code, cur, prev, hp;
  logic [15:0] accum_i, rd, mask, req, em, er, ddat;
  logic [10:0] dsel, dsel_o;
  logic [4:0] ext, rdy;
  logic [9:0] cause;
  logic [119:0] ctx, rest, x1;
  logic [31:0] seed, r;
  logic [3:0] xl [5] = '{4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  plp_ctl uut (.clock_i, .rst_b_i, .op_valid_i, .op_code_i, .op_sel_i,
    .accum_i, .device_register_select_i(dsel), .instr_boundary_i(bnd),
    .ext_irq_i(ext), .status_cause_i(cause), .ctx_work_i(ctx),
    .read_data_o(rd), .read_valid_o(rv), .current_level_o(cur),
    .previous_level_o(prev), .highest_pending_level_o(hp),
    .level_enable_mask_o(mask), .level_request_flags_o(req),
    .interrupts_on_o(intr_on), .cpu_hold_o(hold), .switch_done_o(done),
    .ctx_restore_o(rest), .device_io_transfer_o(dio),
    .device_register_select_o(dsel_o), .device_data_o(ddat));
  plp_cpu_model cpu (.clock_i, .rst_b_i, .cpu_hold_i(hold),
    .dev_ready_i(rdy), .instr_boundary_o(bnd), .ext_irq_o(ext),
    .irq_cnt_o());
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [3:0] top(input logic [15:0] v);
    top = 4'h0;
    for (int i = 0; i < 16; i++)
      if (v[i]) top = 4'(i);
  endfunction : top
  function automatic logic [15:0] apply(input logic [3:0] c,
    input logic [15:0] v, input logic [15:0] a);
    if (c == 4'h2) return a;
    else if (c == 4'h3) return v | a;
    else return v & ~a;
  endfunction : apply
  task automatic check(input string n, input logic [119:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic results();
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic op(input logic [3:0] c, input logic s,
    input logic [15:0] a);
    @(posedge clock_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_sel_i <= s;
    accum_i <= a;
    @(posedge clock_i);
    op_valid_i <= 1'b0;
    #1;
  endtask : op
  task automatic wait_sw();
    int h;
    h = 0;
    for (int i = 0; i < 400 && done !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
      if (hold === 1'b1) h++;
    end
    check("done", done, 1'b1);
    check("hold time", 16'(h), 16'(plp_pkg::SWITCH_CYCLES));
  endtask : wait_sw
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // the whole run needs about 1300 cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      results();
    end
  end
  initial begin
    rst_b_i = 1'b0;
    op_valid_i = 1'b0;
    op_code_i = 4'h0;
    op_sel_i = 1'b0;
    accum_i = 16'h0000;
    dsel = 11'h000;
    cause = 10'h000;
    rdy = 5'h00;
    seed = 32'hCB445140;
    em = 16'h0000;
    er = 16'h0000;
    ctx = 120'({rnd(), rnd(), rnd(), rnd()});
    repeat (4) @(posedge clock_i);
    check("regs", {mask, req}, 32'h0);
    check("levels", {intr_on, hold, cur, prev}, 10'h000);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      code = (r[1:0] == 2'h3) ? 4'h4 : 4'h2 + {2'h0, r[1:0]};
      op(code, r[2], r[31:16]);
      if (r[2]) er = apply(code, er, r[31:16]);
      else em = apply(code, em, r[31:16]);
      check("mask", mask, em);
      check("flags", req, er);
      @(posedge clock_i);
      #1;
      check("pending", hp, top(em & er));
      op(4'h1, r[3], 16'h0000);
      check("read", {rv, rd}, {1'b1, r[3] ? er : em});
    end
    for (int i = 0; i < 10; i++) begin
      op(4'h2, 1'b1, 16'h0000);
      @(posedge clock_i);
      cause <= 10'h001 << i;
      @(posedge clock_i);
      cause <= 10'h000;
      repeat (3) @(posedge clock_i);
      #1;
      check("status", req, 16'h4000);
    end
    foreach (xl[i]) begin
      op(4'h2, 1'b1, 16'h0000);
      @(posedge clock_i);
      rdy <= 5'h01 << i;
      @(posedge clock_i);
      rdy <= 5'h00;
      repeat (16) @(posedge clock_i);
      #1;
      check("ext", req, 16'h0001 << xl[i]);
    end
    op(4'h2, 1'b0, 16'hFFFF);
    op(4'h2, 1'b1, 16'h0021);
    x1 = ctx;
    op(4'h6, 1'b0, 16'h0000);
    wait_sw();
    check("levels", {cur, prev}, 8'h50);
    @(posedge clock_i);
    ctx <= ~x1;
    op(4'h5, 1'b0, 16'h0000);
    check("give up", req, 16'h0001);
    wait_sw();
    check("levels", {cur, prev}, 8'h05);
    check("context", rest, x1);
    op(4'h7, 1'b0, 16'h0000);
    op(4'h2, 1'b1, 16'h0100);
    repeat (20) @(posedge clock_i);
    check("frozen", {intr_on, hold, cur}, 6'h00);
    op(4'h6, 1'b0, 16'h0000);
    wait_sw();
    check("levels", {intr_on, cur, prev}, 9'h180);
    r = rnd();
    @(posedge clock_i);
    dsel <= r[10:0];
    op(4'h8, 1'b0, r[31:16]);
    check("device", {dio, dsel_o, ddat}, {1'b1, r[10:0], r[31:16]});
    results();
  end
endmodule : tb_top
